// ### tb/hpm_props.sv
// Checker for the host port link between master and processor end.
// Assumes one clock domain; instantiated beside the interface in tb_top.
module hpm_props
  import hpm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Link signals
  input wire logic host_data_strobe_n,
  input wire logic host_read_write,
  input wire logic access_select_hi,
  input wire logic access_select_lo,
  input wire logic half_word_select,
  input wire logic [hpm_pkg::NPROC-1:0] proc_chip_select_n,
  input wire logic [hpm_pkg::NPROC-1:0] proc_reset_n,
  input wire logic m_data_oe,
  input wire logic p_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Link properties
  // ********************
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // First and second half-word strobes
  sequence s_first;
    $fell(host_data_strobe_n) && !half_word_select;
  endsequence
  sequence s_second;
    $fell(host_data_strobe_n) && half_word_select;
  endsequence
  a_strobe_width: assert property ($fell(host_data_strobe_n) |-> ##1 !host_data_strobe_n ##1 host_data_strobe_n)
    else $error("strobe width wrong");
  a_half_order: assert property (s_first |-> ##[3:40] s_second)
    else $error("second half-word missing");
  a_one_select: assert property (!host_data_strobe_n |-> $onehot(~proc_chip_select_n))
    else $error("no single chip select in strobe");
  a_select_stable: assert property (!host_data_strobe_n && !$past(host_data_strobe_n) |->
    $stable({access_select_hi, access_select_lo, half_word_select, host_read_write}))
    else $error("selects moved in strobe");
  a_reset_sticky: assert property (!(|($past(proc_reset_n) & ~proc_reset_n)))
    else $error("processor reset asserted again");
  a_write_drive: assert property (!host_data_strobe_n && host_read_write == RW_WRITE |-> m_data_oe)
    else $error("write strobe without bus drive");
  a_read_release: assert property (!host_data_strobe_n && host_read_write == RW_READ |-> !m_data_oe)
    else $error("master drives bus in read");
  a_no_contend: assert property (!(m_data_oe && p_data_oe))
    else $error("both ends drive the bus");
endmodule // hpm_props

// ### tb/tb_top.sv
// Testbench joining master and one processor end through the interface.
// Assumes processor 0 only is populated; the bench resolves the data bus.
module tb_top;
  import hpm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // Stimulus and wiring
  // ********************
  logic clock, arst_n, cmd_valid, cmd_ready, cmd_read, irq_out, rsp_valid, rsp_ready;
  logic tgl = 1'b0;
  logic strobe_q = 1'b1;
  logic interrupt_bit, emulation_off_n;
  logic [3:0] family_sel, reset_release, irq_enable, cmd_byte_en;
  logic [1:0] cmd_proc;
  hpm_acc_t cmd_acc;
  logic [31:0] cmd_wdata, rsp_data;
  logic [15:0] read_value, last_write, read_base;
  logic [5:0] mon_q[$];
  int n_fail, comparisons;
  localparam logic [1:0] CODE_A[4] = '{SEL_A_ADDR, SEL_A_CTRL, SEL_A_DATA_INC, SEL_A_DATA};
  localparam logic [1:0] CODE_B[4] = '{SEL_B_ADDR, SEL_B_CTRL, SEL_B_DATA_INC, SEL_B_DATA};
  hpm_if hpm_if_i();
  // Released bus shows a pattern that changes every cycle
  assign hpm_if_i.host_addr_data_bus = hpm_if_i.m_data_oe ? hpm_if_i.m_data_out :
    hpm_if_i.p_data_oe ? hpm_if_i.p_data_out : {8{tgl, ~tgl}};
  // Read source inverts in the second half-word so a swap of halves shows
  assign read_value = read_base ^ {16{hpm_if_i.half_word_select}};
  hpm_master hpm_master_i (.clock(clock), .arst_n(arst_n), .family_sel(family_sel),
    .reset_release(reset_release), .irq_enable(irq_enable), .irq_out(irq_out), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_proc(cmd_proc), .cmd_read(cmd_read), .cmd_acc(cmd_acc),
    .cmd_byte_en(cmd_byte_en), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_data(rsp_data), .link(hpm_if_i.master));
  hpm_proc hpm_proc_i (.clock(clock), .arst_n(arst_n), .family_sel(family_sel[0]),
    .interrupt_bit(interrupt_bit), .emulation_off_n(emulation_off_n), .read_value(read_value),
    .last_write(last_write), .link(hpm_if_i.proc));
  hpm_props hpm_props_i (.clock(clock), .arst_n(arst_n), .host_data_strobe_n(hpm_if_i.host_data_strobe_n),
    .host_read_write(hpm_if_i.host_read_write), .access_select_hi(hpm_if_i.access_select_hi),
    .access_select_lo(hpm_if_i.access_select_lo), .half_word_select(hpm_if_i.half_word_select),
    .proc_chip_select_n(hpm_if_i.proc_chip_select_n), .proc_reset_n(hpm_if_i.proc_reset_n),
    .m_data_oe(hpm_if_i.m_data_oe), .p_data_oe(hpm_if_i.p_data_oe));
  // Clock source
  initial begin
    clock = 0;
    forever #10 clock = ~clock;
  end
  // Records the link pins at each strobe start
  always @(posedge clock) begin
    tgl <= ~tgl;
    strobe_q <= hpm_if_i.host_data_strobe_n;
    if (strobe_q && !hpm_if_i.host_data_strobe_n) begin
      mon_q.push_back({hpm_if_i.half_word_select, hpm_if_i.host_read_write, hpm_if_i.access_select_hi,
        hpm_if_i.access_select_lo, hpm_if_i.byte_enable_hi_n, hpm_if_i.byte_enable_lo_n});
    end
  end
  // ********************
  // Tasks
  // ********************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Offers one command to processor 0; ok tells whether it was taken
  task automatic do_cmd(input logic rd, input int acc, input logic [31:0] wd, output logic ok);
    ok = 0;
    cmd_valid <= 1;
    cmd_read <= rd;
    cmd_acc <= hpm_acc_t'(acc);
    cmd_byte_en <= 4'h9;
    cmd_wdata <= wd;
    for (int i = 0; i < 40 && !ok; i++) begin
      @(posedge clock);
      ok = (cmd_ready === 1'h1);
    end
    cmd_valid <= 0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 60; i++) begin
      @(posedge clock);
      if (cmd_ready === 1'h1) return;
    end
    n_fail++;
    finish_test();
  endtask
  task automatic t_reset();
    check(hpm_if_i.host_data_strobe_n, 1);
    check(hpm_if_i.proc_chip_select_n, 4'hf);
    check(hpm_if_i.proc_ready_in[0], 1);
    check(hpm_if_i.proc_reset_n, 4'h0);
    arst_n <= 1;
    repeat (3) @(posedge clock);
    check(hpm_if_i.proc_interrupt_in[0], 1);
    reset_release <= 4'h1;
    @(posedge clock);
    reset_release <= 4'h0;
    repeat (3) @(posedge clock);
    check(hpm_if_i.proc_reset_n, 4'h1);
  endtask
  // Every access kind for one family, byte enables 1001
  task automatic t_access(input logic fam);
    logic ok;
    logic [1:0] code;
    family_sel <= {3'h0, fam};
    @(posedge clock);
    for (int a = 0; a < 4; a++) begin
      mon_q.delete();
      code = fam ? CODE_B[a] : CODE_A[a];
      do_cmd(0, a, 32'h1234abc0 + a, ok);
      wait_idle();
      @(posedge clock);
      check(ok, 1);
      check(mon_q.size(), 2);
      check(mon_q[0], {1'h0, RW_WRITE, code, fam ? 2'h1 : 2'h3});
      check(mon_q[1], {1'h1, RW_WRITE, code, fam ? 2'h2 : 2'h3});
      check(last_write, 16'habc0 + a);
    end
  endtask
  // Reads fill the answer FIFO while the user stalls, then drain it
  task automatic t_read_fifo();
    logic ok;
    int n;
    logic got;
    n = 0;
    mon_q.delete();
    rsp_ready <= 0;
    read_base <= 16'h3c5a;
    for (int i = 0; i < 6; i++) begin
      do_cmd(1, 3, 0, ok);
      @(posedge clock);
      if (ok) n++;
    end
    check(n, FIFO_DEPTH + 1);
    check(mon_q[0][4], RW_READ);
    rsp_ready <= 1;
    for (int k = 0; k < n; k++) begin
      got = 0;
      for (int j = 0; j < 60 && !got; j++) begin
        @(posedge clock);
        got = (rsp_valid === 1'h1);
      end
      if (!got) begin
        n_fail++;
        finish_test();
      end
      check(rsp_data, 32'h3c5ac3a5);
    end
    repeat (20) @(posedge clock);
    check(rsp_valid, 0);
  endtask
  task automatic t_irq();
    irq_enable <= 4'h1;
    for (int b = 0; b < 2; b++) begin
      interrupt_bit <= b[0];
      repeat (4) @(posedge clock);
      check(irq_out, !b[0]);
    end
    interrupt_bit <= 0;
    irq_enable <= 4'h0;
    repeat (4) @(posedge clock);
    check(irq_out, 0);
    emulation_off_n <= 0;
    repeat (2) @(posedge clock);
    check({hpm_if_i.proc_ready_oe[0], hpm_if_i.proc_interrupt_oe[0]}, 2'h0);
    emulation_off_n <= 1;
  endtask
  // ********************
  // Main sequence
  // ********************
  initial begin
    {arst_n, cmd_valid, cmd_read, rsp_ready, interrupt_bit} = 5'h0;
    emulation_off_n = 1'b1;
    {family_sel, reset_release, irq_enable, cmd_byte_en, cmd_proc} = 18'h0;
    cmd_acc = ACC_ADDR;
    cmd_wdata = 32'h0;
    read_base = 16'h0;
    repeat (6) @(posedge clock);
    t_reset();
    t_access(0);
    t_access(1);
    t_read_fifo();
    t_irq();
    finish_test();
  end
endmodule // tb_top

// ### verilog/hpm_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock domain.
module hpm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("hpm_fifo depth must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;
  // Flags and pointer update
  always_comb begin
    in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
    out_valid = wp_r != rp_r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    out_data = mem_r[rp_r[AW-1:0]];
  end
  // Pointer registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end
  // Storage, no reset needed
  always_ff @(posedge clock) begin
    if (push) mem_r[wp_r[AW-1:0]] <= in_data;
  end
endmodule // hpm_fifo

// ### verilog/hpm_if.sv
// Shared pin bundle between the host port master and one processor end.
// Assumes the bench resolves the data bus from the two output enables.
interface hpm_if;
  import hpm_pkg::*;
  logic host_data_strobe_n;
  logic host_read_write;
  logic access_select_hi;
  logic access_select_lo;
  logic half_word_select;
  logic byte_enable_hi_n;
  logic byte_enable_lo_n;
  logic [NPROC-1:0] proc_chip_select_n;
  logic [NPROC-1:0] proc_ready_in;
  logic [NPROC-1:0] proc_ready_oe;
  logic [NPROC-1:0] proc_interrupt_in;
  logic [NPROC-1:0] proc_interrupt_oe;
  logic [NPROC-1:0] proc_reset_n;
  logic [DW-1:0] m_data_out;
  logic m_data_oe;
  logic [DW-1:0] p_data_out;
  logic p_data_oe;
  logic [DW-1:0] host_addr_data_bus;
  modport master (output host_data_strobe_n, host_read_write, access_select_hi, access_select_lo,
    half_word_select, byte_enable_hi_n, byte_enable_lo_n, proc_chip_select_n, proc_reset_n,
    m_data_out, m_data_oe, input proc_ready_in, proc_interrupt_in, host_addr_data_bus);
  modport proc (input host_data_strobe_n, host_read_write, access_select_hi, access_select_lo,
    half_word_select, byte_enable_hi_n, byte_enable_lo_n, proc_chip_select_n, proc_reset_n,
    host_addr_data_bus, output proc_ready_in, proc_ready_oe, proc_interrupt_in, proc_interrupt_oe,
    p_data_out, p_data_oe);
endinterface

// ### verilog/hpm_master.sv
// Host port master: runs 32-bit word accesses as two half-word strobes.
// Assumes the far processors follow the ready and interrupt conventions.
module hpm_master
  import hpm_pkg::*;
#(
  parameter int NP = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Processor family, reset release and interrupt
  input wire logic [NP-1:0] family_sel,
  input wire logic [NP-1:0] reset_release,
  input wire logic [NP-1:0] irq_enable,
  output logic irq_out,
  // Command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_proc,
  input wire logic cmd_read,
  input wire hpm_pkg::hpm_acc_t cmd_acc,
  input wire logic [3:0] cmd_byte_en,
  input wire logic [31:0] cmd_wdata,
  // Read answers through FIFO
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [31:0] rsp_data,
  // Link
  hpm_if.master link
);
  import hpm_pkg::*;
  // ********************
  // Parameter checks
  // ********************
  // Chip select decode and the strobe counter are sized for these values only
  if (NP != NPROC) begin : g_bad_np
    $error("hpm_master supports exactly four processors");
  end
  if (STROBE_CYC < 1 || STROBE_CYC > 4) begin : g_bad_strobe
    $error("hpm_master strobe count does not fit its counter");
  end
  // ********************
  // State
  // ********************
  typedef enum {ST_IDLE, ST_WAIT, ST_STROBE, ST_GAP, ST_PUSH} hpm_state_t;
  hpm_state_t st_r, st_nxt;
  logic half_r, half_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [1:0] proc_r, proc_nxt;
  logic rd_r, rd_nxt;
  hpm_acc_t acc_r, acc_nxt;
  logic [3:0] be_r, be_nxt;
  logic [31:0] wd_r, wd_nxt, rd_data_r, rd_data_nxt;
  logic [NP-1:0] cs_n_r, cs_n_nxt;
  logic [NP-1:0] rst_n_r, rst_n_nxt;
  logic irq_r, irq_nxt;
  logic fam_r, fam_nxt;
  logic [DW-1:0] mdo_r, mdo_nxt;
  logic fam, rdy, f_ready;
  // ********************
  // Ready decode
  // ********************
  // Ready polarity per family
  // Family is latched per access so polarity and codes cannot move mid-strobe
  always_comb begin
    fam = fam_r;
    rdy = fam ? !link.proc_ready_in[proc_r] : link.proc_ready_in[proc_r];
  end
  // ********************
  // Sequencer
  // ********************
  // Transfer sequencer
  always_comb begin
    st_nxt = st_r;
    half_nxt = half_r;
    cnt_nxt = cnt_r;
    proc_nxt = proc_r;
    rd_nxt = rd_r;
    acc_nxt = acc_r;
    be_nxt = be_r;
    wd_nxt = wd_r;
    rd_data_nxt = rd_data_r;
    cs_n_nxt = cs_n_r;
    fam_nxt = fam_r;
    cmd_ready = 1'b0;
    case (st_r)
      ST_IDLE: begin
        cmd_ready = 1'b1;
        if (cmd_valid) begin
          proc_nxt = cmd_proc;
          rd_nxt = cmd_read;
          acc_nxt = cmd_acc;
          be_nxt = cmd_byte_en;
          wd_nxt = cmd_wdata;
          half_nxt = 1'b0;
          cs_n_nxt = ~(4'h1 << cmd_proc);
          fam_nxt = family_sel[cmd_proc];
          st_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // A processor that never shows ready stalls the port here
        cnt_nxt = 2'h0;
        if (rdy) st_nxt = ST_STROBE;
      end
      ST_STROBE: begin
        cnt_nxt = cnt_r + 2'h1;
        if (32'(cnt_r) == STROBE_CYC - 1) begin
          if (rd_r && !half_r) rd_data_nxt[31:16] = link.host_addr_data_bus;
          if (rd_r && half_r) rd_data_nxt[15:0] = link.host_addr_data_bus;
          st_nxt = ST_GAP;
        end
      end
      ST_GAP: begin
        if (!half_r) begin
          half_nxt = 1'b1;
          st_nxt = ST_WAIT;
        end else begin
          st_nxt = rd_r ? ST_PUSH : ST_IDLE;
        end
      end
      // A full answer queue holds the port until the user drains it
      ST_PUSH: if (f_ready) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end
  // ********************
  // Resets, interrupt and write data
  // ********************
  // Resets and interrupt combine
  always_comb begin
    rst_n_nxt = rst_n_r | reset_release;
    irq_nxt = |(~link.proc_interrupt_in & irq_enable);
    // Half-word that the next strobe carries, kept in a flip-flop
    mdo_nxt = half_nxt ? wd_nxt[15:0] : wd_nxt[31:16];
  end
  // ********************
  // Registers
  // ********************
  // State registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= ST_IDLE;
      half_r <= 1'b0;
      cnt_r <= 2'h0;
      proc_r <= 2'h0;
      rd_r <= 1'b0;
      acc_r <= ACC_ADDR;
      be_r <= 4'h0;
      wd_r <= 32'h0;
      rd_data_r <= 32'h0;
      cs_n_r <= 4'hf;
      rst_n_r <= 4'h0;
      irq_r <= 1'b0;
      fam_r <= 1'b0;
      mdo_r <= '0;
    end else begin
      st_r <= st_nxt;
      half_r <= half_nxt;
      cnt_r <= cnt_nxt;
      proc_r <= proc_nxt;
      rd_r <= rd_nxt;
      acc_r <= acc_nxt;
      be_r <= be_nxt;
      wd_r <= wd_nxt;
      rd_data_r <= rd_data_nxt;
      cs_n_r <= cs_n_nxt;
      rst_n_r <= rst_n_nxt;
      irq_r <= irq_nxt;
      fam_r <= fam_nxt;
      mdo_r <= mdo_nxt;
    end
  end
  // ********************
  // Answer queue
  // ********************
  // Read data queue
  hpm_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .arst_n(arst_n),
    .in_valid(st_r == ST_PUSH),
    .in_ready(f_ready),
    .in_data(rd_data_r),
    .out_valid(rsp_valid),
    .out_ready(rsp_ready),
    .out_data(rsp_data)
  );
  // ********************
  // Pins
  // ********************
  // Active-low byte enable for the half on the pins; idle high for the family without them
  function automatic logic be_pin_n(input logic use_be, input logic half, input logic b_first, input logic b_second);
    return use_be ? !(half ? b_second : b_first) : 1'b1;
  endfunction
  // Pin drive
  always_comb begin
    link.host_data_strobe_n = !(st_r == ST_STROBE);
    link.host_read_write = rd_r ? RW_READ : RW_WRITE;
    {link.access_select_hi, link.access_select_lo} = acc_code(fam, acc_r);
    link.half_word_select = half_r;
    link.byte_enable_hi_n = be_pin_n(fam, half_r, be_r[3], be_r[1]);
    link.byte_enable_lo_n = be_pin_n(fam, half_r, be_r[2], be_r[0]);
    link.proc_chip_select_n = cs_n_r;
    link.proc_reset_n = rst_n_r;
    link.m_data_out = mdo_r;
    link.m_data_oe = !rd_r && (st_r == ST_STROBE);
    irq_out = irq_r;
  end
endmodule // hpm_master

// ### verilog/hpm_pkg.sv
// Package for the host port master and its processor-side end.
// Assumes one 50 MHz clock shared by both ends and an active-low async reset.
//
// Overview of operation
// - Active-low data strobe frames each transfer
// - Four interrupt inputs, optional combined interrupt out
// - Processor drives interrupt, high in reset
// - Byte enables driven only for byte-enable family
// - Half-word select low first, high second
// - Access-select codes depend on processor family
// - Four chip selects, selected held low
// - Ready polarity follows processor family
// - Processor drops ready while finishing internally
// - Ready reads asserted when chip select high
// - Ready floats while emulation off active
// - Resets asserted on global reset, software releases
// - Read/write low for write, high read
package hpm_pkg;
  localparam int NPROC = 4;
  localparam int DW = 16;
  localparam int FIFO_DEPTH = 4;
  // Processor family: 0 ready active high, 1 ready active low with byte enables
  localparam logic FAM_A = 1'h0;
  localparam logic FAM_B = 1'h1;
  // Access kinds
  typedef enum logic [1:0] {ACC_ADDR, ACC_CTRL, ACC_DATA_INC, ACC_DATA} hpm_acc_t;
  // Access-select codes per family
  localparam logic [1:0] SEL_A_CTRL = 2'h0;
  localparam logic [1:0] SEL_A_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_A_ADDR = 2'h2;
  localparam logic [1:0] SEL_A_DATA = 2'h3;
  localparam logic [1:0] SEL_B_CTRL = 2'h0;
  localparam logic [1:0] SEL_B_ADDR = 2'h1;
  localparam logic [1:0] SEL_B_DATA_INC = 2'h2;
  localparam logic [1:0] SEL_B_DATA = 2'h3;
  // Strobe width in clock cycles
  localparam int STROBE_NS = 40;
  localparam int CLK_NS = 20;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ = 1'h1;

  // Family-dependent access-select encoding
  function automatic logic [1:0] acc_code(input logic fam, input hpm_acc_t acc);
    logic [1:0] c;
    c = 2'h0;
    case (acc)
      ACC_ADDR: c = fam ? SEL_B_ADDR : SEL_A_ADDR;
      ACC_CTRL: c = fam ? SEL_B_CTRL : SEL_A_CTRL;
      ACC_DATA_INC: c = fam ? SEL_B_DATA_INC : SEL_A_DATA_INC;
      default: c = fam ? SEL_B_DATA : SEL_A_DATA;
    endcase
    return c;
  endfunction
endpackage

// ### verilog/hpm_proc.sv
// Processor-side end: a simple host port slave model in logic.
// Assumes the master holds selects stable during the strobe.
module hpm_proc
  import hpm_pkg::*;
#(
  parameter int IDX = 0,
  parameter int BUSY_CYC = 2
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // User side
  input wire logic family_sel,
  input wire logic interrupt_bit,
  input wire logic emulation_off_n,
  input wire logic [DW-1:0] read_value,
  output logic [DW-1:0] last_write,
  // Link
  hpm_if.proc link
);
  import hpm_pkg::*;
  // Index must name a link slot and the busy count must fit its counter
  if (IDX < 0 || IDX >= NPROC || BUSY_CYC < 1 || BUSY_CYC > 15) begin : g_bad_param
    $error("hpm_proc bad parameters");
  end
  logic [3:0] busy_r, busy_nxt;
  logic ds_r, ds_nxt;
  logic [DW-1:0] lw_r, lw_nxt;
  logic sel, busy;
  // Busy count starts at strobe release
  always_comb begin
    sel = !link.proc_chip_select_n[IDX];
    ds_nxt = link.host_data_strobe_n;
    busy_nxt = (busy_r != 4'h0) ? busy_r - 4'h1 : 4'h0;
    if (sel && !ds_r && link.host_data_strobe_n) busy_nxt = 4'(BUSY_CYC);
    lw_nxt = lw_r;
    if (sel && !link.host_data_strobe_n && !link.host_read_write) lw_nxt = link.host_addr_data_bus;
    busy = busy_r != 4'h0;
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_r <= 4'h0;
      ds_r <= 1'b1;
      lw_r <= '0;
    end else begin
      busy_r <= busy_nxt;
      ds_r <= ds_nxt;
      lw_r <= lw_nxt;
    end
  end
  // Pin drive
  always_comb begin
    link.proc_ready_in[IDX] = (sel && busy) ? family_sel : !family_sel;
    link.proc_ready_oe[IDX] = emulation_off_n;
    link.proc_interrupt_in[IDX] = !link.proc_reset_n[IDX] ? 1'b1 : interrupt_bit;
    link.proc_interrupt_oe[IDX] = emulation_off_n;
    link.p_data_out = read_value;
    link.p_data_oe = sel && !link.host_data_strobe_n && link.host_read_write;
    last_write = lw_r;
  end
endmodule // hpm_proc
